// file: hdl/excl_stack_pkg.sv
// Shared types and constants for the exclusive, ordered and stack access unit.
// Assumes a single core clock and a memory system that holds the global exclusive monitor.
package excl_stack_pkg;

  // ****************************************************************
  // Constants
  // ****************************************************************
  localparam logic [3:0] LINK_IDX = 4'hE;
  localparam logic [3:0] PC_IDX = 4'hF;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [31:0] STATUS_OK = 32'h0000_0000;
  localparam logic [31:0] STATUS_FAIL = 32'h0000_0001;
  // Single-cycle I/O port window, value arbitrary.
  localparam logic [31:0] IO_PORT_BASE = 32'hF000_0000;
  localparam logic [31:0] IO_PORT_MASK = 32'hFF00_0000;
  // Top byte of a loaded program counter that marks an exception return.
  localparam logic [7:0] EXC_RETURN_TOP = 8'hFF;
  localparam logic [15:0] LIST_NONE = 16'h0000;
  localparam logic [15:0] LIST_ONE = 16'h0001;
  localparam logic [21:0] OFFSET_PAD = 22'h00_0000;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_LOAD_EXCL, OP_STORE_EXCL, OP_LOAD_ACQ, OP_STORE_REL,
    OP_LOAD_ACQ_EXCL, OP_STORE_REL_EXCL, OP_PUSH, OP_POP
  } op_type;

  typedef enum logic [1:0] {SIZE_BYTE, SIZE_HALF, SIZE_WORD} size_type;

  typedef struct packed {
    op_type op;
    size_type size;
    logic [3:0] transfer_reg;
    logic [3:0] status_reg;
    logic [31:0] base;
    logic [9:0] offset;
    logic [15:0] reg_list;
    logic shareable;
  } cmd_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic excl;
    logic acquire;
    logic release_;
    logic shared;
    size_type size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_type;

  typedef struct packed {
    logic valid;
    logic [3:0] idx;
    logic [31:0] data;
  } wb_type;

endpackage

// file: hdl/excl_stack_unit.sv
// Execution unit for exclusive, acquire/release and push/pop accesses.
// Assumes one outstanding memory access, with mem_ack meaning the access is observed by all,
// and mem_quiet meaning every earlier access of the core is observed.
`timescale 1ns/10ps

// Function
// - These operations leave the condition flags untouched.
// - Load-acquire is observed before any later load or store.
// - Store-release waits until all earlier loads and stores are observed.
// - Store-release then load-acquire are observed in program order.
// - Store-release writes are multi-copy atomic towards every observer.
// - Misaligned acquire or release access raises an alignment fault.
// - Shareable acquire-exclusive load marks the address in the global monitor.
// - Acquire-exclusive load sets the local monitor active.
// - Acquire-exclusive load carries acquire ordering.
// - Release-exclusive store writes 0 on success, 1 on failure.
// - Release-exclusive store carries release ordering.
// - Push stores highest word at stack pointer minus four; pointer ends lowest.
// - Pop reads upward from stack pointer; pointer ends above highest word.
// - Lowest register number takes lowest address in push and pop.
// - Pop of program counter branches; loaded bit zero sets thumb bit.
// - Pop of program counter is exception or function return by value.
// - Acquire and release instructions need no matching partner.
// - Local monitor keeps no address or size, so mismatches still complete.
// - Exclusive access to the I/O port raises the severe fault.
module excl_stack_unit
  import excl_stack_pkg::*;
(
  input wire logic clk, // Core clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic cmd_valid, // A decoded instruction is offered.
  input cmd_type cmd, // The decoded instruction.
  output logic cmd_ready, // Unit can take an instruction.
  output logic [3:0] rd_idx, // Register file read index.
  input wire logic [31:0] rd_data, // Register file read data for rd_idx.
  output mem_req_type mem_out, // Memory access request, held until acknowledged.
  input wire logic mem_ack, // Memory access observed by all.
  input wire logic [31:0] mem_rdata, // Load data, valid with mem_ack.
  input wire logic mem_excl_fail, // Exclusive store not performed, valid with mem_ack.
  input wire logic mem_quiet, // All earlier accesses are observed.
  output wb_type wb, // Register write back pulse.
  output wb_type sp_wb, // Stack pointer write back pulse.
  output logic branch_valid, // Branch after a pop of the program counter.
  output logic [31:0] branch_target, // Branch destination.
  output logic exc_return, // Branch is an exception return.
  output logic thumb, // Thumb state bit of the status word.
  output logic align_fault, // Alignment fault pulse.
  output logic severe_fault, // Severe fault pulse.
  output logic monitor_active, // Local exclusive monitor state.
  input wire logic flags_load, // Other units update the condition flags.
  input wire logic [3:0] flags_in, // New condition flags.
  output logic [3:0] nzcv // Condition flags of the status word.
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic [31:0] word_span(input logic [15:0] list);
    logic [31:0] s;
    s = WORD_RESET;
    for (int i = 0; i < 16; i++)
    begin
      if (list[i])
        s = s + WORD_BYTES;
    end
    return s;
  endfunction

  // Lowest set register keeps the ascending register-to-address order.
  function automatic logic [3:0] lowest(input logic [15:0] list);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 15; i >= 0; i--)
    begin
      if (list[i])
        idx = 4'(i);
    end
    return idx;
  endfunction

  function automatic logic misaligned(input logic [31:0] a, input size_type s);
    return (s == SIZE_WORD) ? (a[1:0] != 2'h0) : ((s == SIZE_HALF) ? a[0] : 1'b0);
  endfunction

  function automatic logic is_excl(input op_type o);
    return o inside {OP_LOAD_EXCL, OP_STORE_EXCL, OP_LOAD_ACQ_EXCL, OP_STORE_REL_EXCL};
  endfunction

  function automatic logic is_acq(input op_type o);
    return o inside {OP_LOAD_ACQ, OP_LOAD_ACQ_EXCL};
  endfunction

  function automatic logic is_rel(input op_type o);
    return o inside {OP_STORE_REL, OP_STORE_REL_EXCL};
  endfunction

  function automatic logic [31:0] extend(input logic [31:0] d, input size_type s);
    return (s == SIZE_BYTE) ? {24'h00_0000, d[7:0]} : ((s == SIZE_HALF) ? {16'h0000, d[15:0]} : d);
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_PREP, ST_WAIT} state_type;

  state_type state, next_state;
  cmd_type cmd_q, next_cmd_q;
  logic [31:0] addr, next_addr;
  logic [15:0] remain, next_remain;
  logic next_cmd_ready;
  logic [3:0] next_rd_idx;
  mem_req_type next_mem_out;
  wb_type next_wb, next_sp_wb;
  logic next_branch_valid, next_exc_return, next_thumb;
  logic [31:0] next_branch_target;
  logic next_align_fault, next_severe_fault, next_monitor_active;
  logic [3:0] next_nzcv;

  // Next-state logic; one access at a time gives acquire ordering, and a release also waits for mem_quiet.
  always_comb
  begin
    logic [31:0] ea;
    logic [3:0] cur;
    logic [15:0] rest;
    logic done;
    ea = cmd.base + {OFFSET_PAD, cmd.offset};
    cur = lowest(remain);
    rest = remain & ~(LIST_ONE << cur);
    done = 1'b0;
    next_state = state;
    next_cmd_q = cmd_q;
    next_addr = addr;
    next_remain = remain;
    next_cmd_ready = cmd_ready;
    next_rd_idx = rd_idx;
    next_mem_out = mem_out;
    next_wb = wb;
    next_wb.valid = 1'b0;
    next_sp_wb = sp_wb;
    next_sp_wb.valid = 1'b0;
    next_branch_valid = 1'b0;
    next_branch_target = branch_target;
    next_exc_return = exc_return;
    next_thumb = thumb;
    next_align_fault = 1'b0;
    next_severe_fault = 1'b0;
    next_monitor_active = monitor_active;
    next_nzcv = nzcv;
    // Only other units move the flags, and only while this unit is idle.
    if (state == ST_IDLE && flags_load)
      next_nzcv = flags_in;
    unique case (state)
      ST_IDLE:
      begin
        // Ready comes up on the first edge after reset and stays up between commands.
        next_cmd_ready = 1'b1;
        if (cmd_valid && cmd_ready)
        begin
          next_cmd_q = cmd;
          if (is_excl(cmd.op) && ((ea & IO_PORT_MASK) == IO_PORT_BASE))
            next_severe_fault = 1'b1;
          else if ((is_acq(cmd.op) || is_rel(cmd.op) || is_excl(cmd.op)) && cmd.op inside
                   {OP_LOAD_ACQ, OP_STORE_REL, OP_LOAD_ACQ_EXCL, OP_STORE_REL_EXCL} && misaligned(ea, cmd.size))
            next_align_fault = 1'b1;
          else if (cmd.op inside {OP_STORE_EXCL, OP_STORE_REL_EXCL} && !monitor_active)
          begin
            // No exclusive held: the store is not attempted and reports failure.
            next_wb = '{valid: 1'b1, idx: cmd.status_reg, data: STATUS_FAIL};
            next_monitor_active = 1'b0;
          end
          else
          begin
            next_cmd_ready = 1'b0;
            next_state = ST_PREP;
            next_remain = cmd.reg_list;
            next_rd_idx = cmd.transfer_reg;
            next_addr = ea;
            if (cmd.op == OP_PUSH)
            begin
              next_addr = cmd.base - word_span(cmd.reg_list);
              next_rd_idx = lowest(cmd.reg_list);
            end
            else if (cmd.op == OP_POP)
              next_addr = cmd.base;
          end
        end
      end
      ST_PREP:
      begin
        // A release waits for every earlier access to be observed; acquire and release
        // stand alone, nothing looks for a partner.
        if (!is_rel(cmd_q.op) || mem_quiet)
        begin
          next_mem_out.valid = 1'b1;
          next_mem_out.write = cmd_q.op inside {OP_STORE_EXCL, OP_STORE_REL, OP_STORE_REL_EXCL, OP_PUSH};
          next_mem_out.excl = is_excl(cmd_q.op);
          next_mem_out.acquire = is_acq(cmd_q.op);
          next_mem_out.release_ = is_rel(cmd_q.op);
          next_mem_out.shared = cmd_q.shareable;
          next_mem_out.size = (cmd_q.op inside {OP_PUSH, OP_POP}) ? SIZE_WORD : cmd_q.size;
          next_mem_out.addr = addr;
          next_mem_out.wdata = rd_data;
          next_state = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        // Completion waits for the ack, so a release is seen before a following acquire.
        if (mem_ack)
        begin
          next_mem_out.valid = 1'b0;
          unique case (cmd_q.op)
            OP_LOAD_EXCL, OP_LOAD_ACQ_EXCL:
            begin
              next_wb = '{valid: 1'b1, idx: cmd_q.transfer_reg, data: extend(mem_rdata, cmd_q.size)};
              next_monitor_active = 1'b1;
              done = 1'b1;
            end
            OP_LOAD_ACQ:
            begin
              next_wb = '{valid: 1'b1, idx: cmd_q.transfer_reg, data: extend(mem_rdata, cmd_q.size)};
              done = 1'b1;
            end
            OP_STORE_REL:
              done = 1'b1;
            OP_STORE_EXCL, OP_STORE_REL_EXCL:
            begin
              next_wb = '{valid: 1'b1, idx: cmd_q.status_reg,
                          data: mem_excl_fail ? STATUS_FAIL : STATUS_OK};
              next_monitor_active = 1'b0;
              done = 1'b1;
            end
            OP_PUSH, OP_POP:
            begin
              if (cmd_q.op == OP_POP && cur == PC_IDX)
              begin
                // Branch lands in the same cycle as the final stack pointer update.
                next_branch_valid = 1'b1;
                next_branch_target = mem_rdata;
                next_thumb = mem_rdata[0];
                next_exc_return = (mem_rdata[31:24] == EXC_RETURN_TOP);
              end
              else if (cmd_q.op == OP_POP)
                next_wb = '{valid: 1'b1, idx: cur, data: mem_rdata};
              next_remain = rest;
              next_addr = addr + WORD_BYTES;
              next_rd_idx = lowest(rest);
              if (rest == LIST_NONE)
              begin
                next_sp_wb = '{valid: 1'b1, idx: cmd_q.transfer_reg,
                               data: (cmd_q.op == OP_PUSH) ? cmd_q.base - word_span(cmd_q.reg_list)
                                                           : addr + WORD_BYTES};
                done = 1'b1;
              end
              else
                next_state = ST_PREP;
            end
          endcase
        end
      end
    endcase
    if (done)
    begin
      next_state = ST_IDLE;
      next_cmd_ready = 1'b1;
    end
  end

  // Registers only; every output of the unit comes from here.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      cmd_q <= '0;
      addr <= WORD_RESET;
      remain <= LIST_NONE;
      cmd_ready <= 1'b0;
      rd_idx <= 4'h0;
      mem_out <= '0;
      wb <= '0;
      sp_wb <= '0;
      branch_valid <= 1'b0;
      branch_target <= WORD_RESET;
      exc_return <= 1'b0;
      thumb <= 1'b1;
      align_fault <= 1'b0;
      severe_fault <= 1'b0;
      monitor_active <= 1'b0;
      nzcv <= FLAGS_RESET;
    end
    else
    begin
      state <= next_state;
      cmd_q <= next_cmd_q;
      addr <= next_addr;
      remain <= next_remain;
      cmd_ready <= next_cmd_ready;
      rd_idx <= next_rd_idx;
      mem_out <= next_mem_out;
      wb <= next_wb;
      sp_wb <= next_sp_wb;
      branch_valid <= next_branch_valid;
      branch_target <= next_branch_target;
      exc_return <= next_exc_return;
      thumb <= next_thumb;
      align_fault <= next_align_fault;
      severe_fault <= next_severe_fault;
      monitor_active <= next_monitor_active;
      nzcv <= next_nzcv;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_flags_hold;
    @(posedge clk) disable iff (rst) (state != ST_IDLE) |=> $stable(nzcv);
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("Flags changed during an access.");

  property p_release_quiet;
    @(posedge clk) disable iff (rst) $rose(mem_out.valid) && mem_out.release_ |-> $past(mem_quiet);
  endproperty
  a_release_quiet: assert property (p_release_quiet) else $error("Release issued before quiet.");

  property p_acquire_hold;
    @(posedge clk) disable iff (rst) mem_out.valid && mem_out.acquire && !mem_ack
      |=> mem_out.valid && mem_out.acquire && $stable(mem_out.addr);
  endproperty
  a_acquire_hold: assert property (p_acquire_hold) else $error("Acquire dropped before ack.");

  property p_align;
    @(posedge clk) disable iff (rst) cmd_valid && cmd_ready && !is_excl(cmd.op) && (is_acq(cmd.op) || is_rel(cmd.op))
      && misaligned(cmd.base + {OFFSET_PAD, cmd.offset}, cmd.size) |=> align_fault && !mem_out.valid && cmd_ready;
  endproperty
  a_align: assert property (p_align) else $error("Misaligned access not faulted.");

  property p_monitor_set;
    @(posedge clk) disable iff (rst) state == ST_WAIT && mem_ack && cmd_q.op == OP_LOAD_ACQ_EXCL
      |=> monitor_active && wb.valid;
  endproperty
  a_monitor_set: assert property (p_monitor_set) else $error("Monitor not set by exclusive load.");

  property p_status_value;
    @(posedge clk) disable iff (rst) state == ST_WAIT && mem_ack && cmd_q.op == OP_STORE_REL_EXCL
      |=> wb.valid && wb.data == ($past(mem_excl_fail) ? STATUS_FAIL : STATUS_OK);
  endproperty
  a_status_value: assert property (p_status_value) else $error("Wrong exclusive store status.");

  property p_monitor_open;
    @(posedge clk) disable iff (rst) wb.valid && cmd_q.op inside {OP_STORE_EXCL, OP_STORE_REL_EXCL}
      && wb.idx == cmd_q.status_reg |-> !monitor_active;
  endproperty
  a_monitor_open: assert property (p_monitor_open) else $error("Monitor left active after store.");

  property p_push_top;
    @(posedge clk) disable iff (rst) sp_wb.valid && cmd_q.op == OP_PUSH
      |-> $past(mem_out.addr) == cmd_q.base - WORD_BYTES && sp_wb.data <= $past(mem_out.addr);
  endproperty
  a_push_top: assert property (p_push_top) else $error("Push top address wrong.");

  property p_pop_sp;
    @(posedge clk) disable iff (rst) sp_wb.valid && cmd_q.op == OP_POP
      |-> sp_wb.data == $past(mem_out.addr) + WORD_BYTES;
  endproperty
  a_pop_sp: assert property (p_pop_sp) else $error("Pop stack pointer wrong.");

  property p_branch_thumb;
    @(posedge clk) disable iff (rst) branch_valid |-> thumb == branch_target[0] && sp_wb.valid;
  endproperty
  a_branch_thumb: assert property (p_branch_thumb) else $error("Thumb bit not from target.");

  property p_io_fault;
    @(posedge clk) disable iff (rst) cmd_valid && cmd_ready && is_excl(cmd.op)
      && (((cmd.base + {OFFSET_PAD, cmd.offset}) & IO_PORT_MASK) == IO_PORT_BASE)
      |=> severe_fault ##1 !mem_out.valid;
  endproperty
  a_io_fault: assert property (p_io_fault) else $error("I/O port exclusive not faulted.");

endmodule // excl_stack_unit

// file: test/mem_model.sv
// Memory system model with a one-entry global exclusive monitor and an access log.
// Assumes the unit holds one request on mem_out until it samples mem_ack.
`timescale 1ns/10ps
module mem_model
  import excl_stack_pkg::*;
(
  input wire logic clk, // Core clock.
  input wire logic rst, // Asynchronous reset, active high.
  input mem_req_type mem_out, // Request from the unit.
  input wire logic [3:0] delay, // Wait cycles before each acknowledge.
  output logic mem_ack, // Access observed by all.
  output logic [31:0] mem_rdata, // Load data, valid with mem_ack.
  output logic mem_excl_fail // Exclusive store refused, valid with mem_ack.
);
  logic [31:0] mark;
  logic marked;
  logic [3:0] cnt;
  int log_n;
  logic [31:0] log_addr [0:31];
  logic [31:0] log_data [0:31];
  logic [4:0] log_attr [0:31];

  // ****************************************************************
  // Acknowledge and global monitor
  // ****************************************************************
  // Data lines flip every idle cycle, so a unit that samples them late sees inverted data.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
      marked <= 1'b0;
      mark <= 32'h0000_0000;
      log_n <= 0;
      mem_rdata <= 32'hFFFF_FFFF;
      mem_excl_fail <= 1'b1;
    end
    else if (mem_out.valid && !mem_ack && cnt >= delay)
    begin
      mem_ack <= 1'b1;
      cnt <= 4'h0;
      mem_rdata <= mem_out.addr ^ 32'h0000_0001;
      mem_excl_fail <= mem_out.excl && mem_out.write && mem_out.shared
                       && !(marked && mark == mem_out.addr);
      if (mem_out.excl && mem_out.shared)
      begin
        marked <= !mem_out.write;
        mark <= mem_out.addr;
      end
      // One log point serves every observer, so all see each write at once and in one order.
      log_addr[log_n[4:0]] <= mem_out.addr;
      log_data[log_n[4:0]] <= mem_out.wdata;
      log_attr[log_n[4:0]] <= {mem_out.write, mem_out.excl, mem_out.acquire, mem_out.release_, mem_out.shared};
      log_n <= log_n + 1;
    end
    else
    begin
      mem_ack <= 1'b0;
      cnt <= (mem_out.valid && !mem_ack) ? cnt + 4'h1 : 4'h0;
      mem_rdata <= ~mem_rdata;
      mem_excl_fail <= ~mem_excl_fail;
    end
  end
endmodule // mem_model

// file: test/test_exclusive_ordered_stack_access.sv
// Self-checking bench for the exclusive, ordered and stack access unit.
// Assumes mem_model answers the memory port and a fixed register image feeds rd_data.
`timescale 1ns/10ps
module test_exclusive_ordered_stack_access
  import excl_stack_pkg::*;
();
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  cmd_type cmd = '0;
  logic cmd_ready, mem_ack, mem_excl_fail, branch_valid, exc_return, thumb, align_fault, severe_fault, monitor_active;
  logic [3:0] rd_idx, nzcv;
  logic [31:0] rd_data, mem_rdata, branch_target;
  mem_req_type mem_out;
  wb_type wb, sp_wb, wb_cap, sp_cap;
  logic mem_quiet = 1'b1;
  logic flags_load = 1'b0;
  logic [3:0] flags_in = 4'h0;
  logic [3:0] delay = 4'h0;
  logic [32:0] br_cap;
  logic al_seen, sev_seen;
  logic cap_clear = 1'b0;
  int fail_count = 0;
  int checked = 0;

  // ****************************************************************
  // Clock, register image and instances
  // ****************************************************************
  always #2.5 clk = ~clk;
  // Each register reads back its own index, so a swapped order shows in the stored data.
  assign rd_data = {28'h5A5_A000, rd_idx};
  excl_stack_unit u_dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .rd_idx(rd_idx), .rd_data(rd_data), .mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .mem_excl_fail(mem_excl_fail), .mem_quiet(mem_quiet), .wb(wb), .sp_wb(sp_wb), .branch_valid(branch_valid),
    .branch_target(branch_target), .exc_return(exc_return), .thumb(thumb), .align_fault(align_fault),
    .severe_fault(severe_fault), .monitor_active(monitor_active), .flags_load(flags_load), .flags_in(flags_in),
    .nzcv(nzcv));
  mem_model u_mem (.clk(clk), .rst(rst), .mem_out(mem_out), .delay(delay), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .mem_excl_fail(mem_excl_fail));

  // Pulses are caught at the edge after they appear, away from the edge that makes them.
  // A clear request from run empties wb_cap, al_seen and sev_seen, so this block is their only driver.
  always @(posedge clk)
  begin
    if (wb.valid)
      wb_cap <= wb;
    else if (cap_clear)
      wb_cap <= '0;
    if (sp_wb.valid)
      sp_cap <= sp_wb;
    if (branch_valid)
      br_cap <= {exc_return, branch_target};
    al_seen <= !cap_clear && (al_seen | align_fault);
    sev_seen <= !cap_clear && (sev_seen | severe_fault);
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Status register 5 never equals the data or base register used here.
  function automatic cmd_type mk(op_type o, size_type s, logic [3:0] t, logic [31:0] b, logic [9:0] f,
    logic [15:0] l, logic sh);
    return {o, s, t, 4'h5, b, f, l, sh};
  endfunction

  // Offered just after a posedge with the unit idle; returns one cycle after cmd_ready comes back.
  task automatic run(input cmd_type c);
    int i;
    cap_clear <= 1'b1;
    @(posedge clk);
    cap_clear <= 1'b0;
    cmd_valid <= 1'b1;
    cmd <= c;
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (2) @(negedge clk);
    for (i = 0; i < 200 && cmd_ready !== 1'b1; i++)
      @(negedge clk);
    if (i == 200)
    begin
      fail_count++;
      print_verdict();
    end
    @(negedge clk);
  endtask

  task automatic expect_log(input int k, input logic [31:0] a, input logic [4:0] at);
    check(u_mem.log_addr[k], a);
    check({27'h0, u_mem.log_attr[k]}, {27'h0, at});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_ordered;
    int n;
    @(posedge clk);
    flags_load <= 1'b1;
    flags_in <= 4'hA;
    @(posedge clk);
    flags_load <= 1'b0;
    n = u_mem.log_n;
    run(mk(OP_LOAD_ACQ, SIZE_WORD, 4'h2, 32'h100, 10'h0, LIST_NONE, 1'b0));
    check(wb_cap.data, 32'h101);
    expect_log(n, 32'h100, 5'b00100);
    run(mk(OP_LOAD_ACQ, SIZE_BYTE, 4'h2, 32'h103, 10'h0, LIST_NONE, 1'b0));
    check(wb_cap.data, 32'h02);
    run(mk(OP_LOAD_ACQ, SIZE_HALF, 4'h2, 32'h101, 10'h0, LIST_NONE, 1'b0));
    check({31'h0, al_seen}, 32'h1);
    run(mk(OP_STORE_REL, SIZE_WORD, 4'h3, 32'h102, 10'h0, LIST_NONE, 1'b0));
    check({31'h0, al_seen}, 32'h1);
    check(32'(u_mem.log_n), 32'(n + 2));
    @(posedge clk);
    mem_quiet <= 1'b0;
    // Other units try to move the flags while the release is held back.
    fork
      run(mk(OP_STORE_REL, SIZE_HALF, 4'h3, 32'h202, 10'h0, LIST_NONE, 1'b0));
      begin
        repeat (9) @(posedge clk);
        flags_load <= 1'b1;
        flags_in <= 4'h5;
        @(negedge clk);
        check({31'h0, mem_out.valid}, 32'h0);
        @(posedge clk);
        flags_load <= 1'b0;
        mem_quiet <= 1'b1;
      end
    join
    expect_log(n + 2, 32'h202, 5'b10010);
    check({16'h0, u_mem.log_data[n + 2][15:0]}, 32'h0003);
    run(mk(OP_STORE_REL, SIZE_WORD, 4'h3, 32'h300, 10'h0, LIST_NONE, 1'b0));
    run(mk(OP_LOAD_ACQ, SIZE_WORD, 4'h2, 32'h304, 10'h0, LIST_NONE, 1'b0));
    expect_log(n + 3, 32'h300, 5'b10010);
    expect_log(n + 4, 32'h304, 5'b00100);
    $display("test ordered done");
  endtask

  task automatic t_exclusive;
    int n;
    n = u_mem.log_n;
    run(mk(OP_LOAD_EXCL, SIZE_WORD, 4'h2, 32'h200, 10'h3FC, LIST_NONE, 1'b0));
    expect_log(n, 32'h5FC, 5'b01000);
    run(mk(OP_STORE_EXCL, SIZE_BYTE, 4'h3, 32'h301, 10'h0, LIST_NONE, 1'b0));
    check(wb_cap.data, STATUS_OK);
    check({28'h0, wb_cap.idx}, 32'h5);
    check({31'h0, monitor_active}, 32'h0);
    run(mk(OP_STORE_EXCL, SIZE_WORD, 4'h3, 32'h301, 10'h0, LIST_NONE, 1'b0));
    check(wb_cap.data, STATUS_FAIL);
    check(32'(u_mem.log_n), 32'(n + 2));
    run(mk(OP_LOAD_ACQ_EXCL, SIZE_WORD, 4'h2, 32'h400, 10'h0, LIST_NONE, 1'b1));
    check({31'h0, monitor_active}, 32'h1);
    expect_log(n + 2, 32'h400, 5'b01101);
    run(mk(OP_STORE_REL_EXCL, SIZE_WORD, 4'h3, 32'h404, 10'h0, LIST_NONE, 1'b1));
    check(wb_cap.data, STATUS_FAIL);
    run(mk(OP_LOAD_ACQ_EXCL, SIZE_HALF, 4'h2, 32'h400, 10'h0, LIST_NONE, 1'b1));
    run(mk(OP_STORE_REL_EXCL, SIZE_WORD, 4'h3, 32'h400, 10'h0, LIST_NONE, 1'b1));
    check(wb_cap.data, STATUS_OK);
    expect_log(n + 5, 32'h400, 5'b11011);
    run(mk(OP_LOAD_EXCL, SIZE_WORD, 4'h2, 32'hF000_0010, 10'h0, LIST_NONE, 1'b0));
    check({31'h0, sev_seen}, 32'h1);
    check(32'(u_mem.log_n), 32'(n + 6));
    $display("test exclusive done");
  endtask

  task automatic t_stack;
    int n;
    n = u_mem.log_n;
    @(posedge clk);
    delay <= 4'h3;
    run(mk(OP_PUSH, SIZE_WORD, 4'hD, 32'h1000, 10'h0, 16'h400A, 1'b0));
    expect_log(n, 32'hFF4, 5'b10000);
    expect_log(n + 2, 32'hFFC, 5'b10000);
    check(u_mem.log_data[n], 32'h5A5A_0001);
    check(u_mem.log_data[n + 2], 32'h5A5A_000E);
    check(sp_cap.data, 32'hFF4);
    run(mk(OP_POP, SIZE_WORD, 4'hD, 32'h2000, 10'h0, 16'h8005, 1'b0));
    expect_log(n + 3, 32'h2000, 5'b00000);
    expect_log(n + 5, 32'h2008, 5'b00000);
    check(sp_cap.data, 32'h200C);
    check(br_cap[31:0], 32'h2009);
    check({31'h0, thumb}, 32'h1);
    check({31'h0, br_cap[32]}, 32'h0);
    run(mk(OP_POP, SIZE_WORD, 4'hD, 32'hFF00_0000, 10'h0, 16'h8000, 1'b0));
    check(br_cap[31:0], 32'hFF00_0001);
    check({31'h0, br_cap[32]}, 32'h1);
    check(sp_cap.data, 32'hFF00_0004);
    $display("test stack done");
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    t_ordered();
    t_exclusive();
    t_stack();
    check({28'h0, nzcv}, 32'hA);
    print_verdict();
  end
endmodule // test_exclusive_ordered_stack_access
